// ===== hdl/action_cmd_unit.sv
// Local design decisions: the address map and register access over Avalon-MM.
`timescale 1ns/1ps
`default_nettype none
`include "action_cmd_params.svh"
module action_cmd_unit (
   input wire logic i_core_clk,
   input wire logic i_srst,
   // Avalon-MM register slave
   input wire logic [5:0] i_avs_address,
   input wire logic i_avs_read,
   input wire logic i_avs_write,
   input wire logic [31:0] i_avs_writedata,
   output logic [31:0] o_avs_readdata,
   output logic o_avs_waitrequest,
   // Memory master for command blocks
   output logic o_mem_rd,
   output logic o_mem_wr,
   output logic [31:0] o_mem_addr,
   output logic [31:0] o_mem_wdata,
   input wire logic i_mem_ack,
   input wire logic [31:0] i_mem_rdata,
   // Transmit byte stream to CSMA/CD unit
   output logic o_tx_valid,
   output logic [7:0] o_tx_data,
   output logic o_tx_is_addr,
   output logic o_tx_last,
   input wire logic i_tx_ready,
   // State toward MAC and system control
   output logic [47:0] o_station_addr,
   output logic o_src_insert_en,
   output logic o_link_enable,
   output action_cmd_pkg::run_state_t o_run_state,
   output logic o_cmd_done_irq,
   output logic o_not_active_irq,
   output logic o_went_idle_irq
);
   import action_cmd_pkg::*;

   ////////////////////////////////////////////////////////////////////
   // Helpers
   ////////////////////////////////////////////////////////////////////

   // Pick one byte lane of a word
   function automatic logic [7:0] byte_sel(input logic [31:0] w,
                                           input logic [1:0] i);
      byte_sel = w[{i, 3'h0} +: 8];
   endfunction

   ////////////////////////////////////////////////////////////////////
   // Register slave state
   ////////////////////////////////////////////////////////////////////

   logic wait_reg, wait_next; // Waitrequest
   logic [31:0] rdata_reg, rdata_next; // Read data
   logic [31:0] base_reg, base_next; // Command unit base
   logic [31:0] off_reg, off_next; // First block offset
   logic start_reg, start_next; // Start pulse
   logic resume_reg, resume_next; // Resume pulse

   ////////////////////////////////////////////////////////////////////
   // Engine state
   ////////////////////////////////////////////////////////////////////

   eng_state_t st_reg, st_next; // Sequencer
   run_state_t run_reg, run_next; // Run state
   logic [31:0] blk_reg, blk_next; // Current block address
   logic [1:0] wcnt_reg, wcnt_next; // Header word count
   logic [15:0] cmdw_reg, cmdw_next; // Command word
   logic [31:0] link_reg, link_next; // Link field
   logic [63:0] par_reg, par_next; // Words at 08h and 0Ch
   logic [63:0] cucfg_reg, cucfg_next; // Command unit bytes
   logic [4:0] idx_reg, idx_next; // Stream byte index
   logic [4:0] end_reg, end_next; // Stream byte count
   logic [31:0] dbuf_reg, dbuf_next; // Fetched stream word
   logic is_sa_reg, is_sa_next; // Stream is address
   logic ok_reg, ok_next; // No-error result
   logic [47:0] sa_reg, sa_next; // Station address
   logic [47:0] shad_reg, shad_next; // Address being built
   logic ins_reg, ins_next; // Source insertion enabled
   logic phyw_reg, phyw_next; // Interface bit written
   logic phy_reg, phy_next; // Interface bit value
   logic mrd_reg, mrd_next; // Memory read request
   logic mwr_reg, mwr_next; // Memory write request
   logic [31:0] maddr_reg, maddr_next; // Memory address
   logic [31:0] mwd_reg, mwd_next; // Memory write data
   logic txv_reg, txv_next; // Stream valid
   logic [7:0] txd_reg, txd_next; // Stream data
   logic txl_reg, txl_next; // Stream last
   logic dn_reg, dn_next; // Done interrupt pulse
   logic na_reg, na_next; // Not-active pulse
   logic wi_reg, wi_next; // Went-idle pulse
   logic [4:0] bc; // Configure byte count
   logic [31:0] sa_word; // Status write image
   logic last_byte; // Final stream byte

   ////////////////////////////////////////////////////////////////////
   // Register slave
   ////////////////////////////////////////////////////////////////////

   // Decode, one wait cycle then answer
   always_comb begin
      wait_next = 1'b1;
      rdata_next = rdata_reg;
      base_next = base_reg;
      off_next = off_reg;
      start_next = 1'b0;
      resume_next = 1'b0;
      if ((i_avs_read || i_avs_write) && wait_reg) begin
         // Answer at the next edge
         wait_next = 1'b0;
         rdata_next = 32'h0000_0000;
         if (i_avs_write) begin
            unique case (i_avs_address[5:2])
               `REG_CTRL: begin
                  start_next = i_avs_writedata[`CTRL_START_BIT];
                  resume_next = i_avs_writedata[`CTRL_RESUME_BIT];
               end
               `REG_BASE: base_next = i_avs_writedata;
               `REG_LIST_OFF: off_next = i_avs_writedata;
               default: ; // Unmapped or read-only: ignored
            endcase
         end else begin
            unique case (i_avs_address[5:2])
               `REG_BASE: rdata_next = base_reg;
               `REG_LIST_OFF: rdata_next = off_reg;
               `REG_STATUS: rdata_next = {27'h0, phyw_reg,
                  o_link_enable, o_src_insert_en, run_reg};
               `REG_SA_LO: rdata_next = sa_reg[31:0];
               `REG_SA_HI: rdata_next = {16'h0, sa_reg[47:32]};
               default: rdata_next = 32'h0000_0000;
            endcase
         end
      end
   end

   // Slave registers
   always_ff @(posedge i_core_clk) begin
      if (i_srst) begin
         wait_reg <= 1'b1;
         rdata_reg <= 32'h0000_0000;
         base_reg <= 32'h0000_0000;
         off_reg <= 32'h0000_0000;
         start_reg <= 1'b0;
         resume_reg <= 1'b0;
      end else begin
         wait_reg <= wait_next;
         rdata_reg <= rdata_next;
         base_reg <= base_next;
         off_reg <= off_next;
         start_reg <= start_next;
         resume_reg <= resume_next;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Command engine
   ////////////////////////////////////////////////////////////////////

   // Byte count is six bits of config byte 0; 32 and up clamp to out of range
   assign bc = par_reg[5] ? 5'h1f : par_reg[4:0];
   // Status image: command word kept, completion set
   assign sa_word = {cmdw_reg, 1'b1, 1'b0, ok_reg, 13'h0000};
   assign last_byte = (idx_reg + 5'h01) == end_reg;

   // Sequencer next state
   always_comb begin
      st_next = st_reg;
      run_next = run_reg;
      blk_next = blk_reg;
      wcnt_next = wcnt_reg;
      cmdw_next = cmdw_reg;
      link_next = link_reg;
      par_next = par_reg;
      cucfg_next = cucfg_reg;
      idx_next = idx_reg;
      end_next = end_reg;
      dbuf_next = dbuf_reg;
      is_sa_next = is_sa_reg;
      ok_next = ok_reg;
      sa_next = sa_reg;
      shad_next = shad_reg;
      ins_next = ins_reg;
      phyw_next = phyw_reg;
      phy_next = phy_reg;
      mrd_next = mrd_reg;
      mwr_next = mwr_reg;
      maddr_next = maddr_reg;
      mwd_next = mwd_reg;
      txv_next = txv_reg;
      txd_next = txd_reg;
      txl_next = txl_reg;
      dn_next = 1'b0;
      na_next = 1'b0;
      wi_next = 1'b0;
      unique case (st_reg)
         ST_IDLE: begin
            // New list from base plus offset
            if (start_reg) begin
               blk_next = base_reg + off_reg;
               maddr_next = base_reg + off_reg;
               mrd_next = 1'b1;
               wcnt_next = 2'h0;
               run_next = RUN_ACTIVE;
               st_next = ST_FETCH;
            end
         end
         ST_SUSP: begin
            // Resume at the saved link, new start at offset
            if (start_reg || resume_reg) begin
               blk_next = base_reg + (start_reg ? off_reg : link_reg);
               maddr_next = base_reg + (start_reg ? off_reg : link_reg);
               mrd_next = 1'b1;
               wcnt_next = 2'h0;
               run_next = RUN_ACTIVE;
               st_next = ST_FETCH;
            end
         end
         ST_FETCH: begin
            // Four consecutive header words, then decode
            if (mrd_reg && i_mem_ack) begin
               unique case (wcnt_reg)
                  2'h0: cmdw_next = i_mem_rdata[31:16];
                  2'h1: link_next = i_mem_rdata;
                  2'h2: par_next[31:0] = i_mem_rdata;
                  2'h3: par_next[63:32] = i_mem_rdata;
               endcase
               wcnt_next = wcnt_reg + 2'h1;
               maddr_next = maddr_reg + 32'h0000_0004;
               if (wcnt_reg == `FETCH_WORDS) begin
                  mrd_next = 1'b0;
                  st_next = ST_DECODE;
               end
            end
         end
         ST_DECODE: begin
            ok_next = 1'b1;
            idx_next = 5'h00;
            st_next = ST_WRST;
            unique case (cmdw_reg[`CMDW_OP_LSB +: 3])
               `CMD_OP_NOP: ok_next = 1'b1;
               `CMD_OP_SA: begin
                  // Stream six address bytes from offset 08h
                  is_sa_next = 1'b1;
                  end_next = `SA_BYTES;
                  st_next = ST_XRD;
               end
               `CMD_OP_CFG: begin
                  if (bc < `CFG_MIN_BYTES || bc > `CFG_MAX_BYTES) begin
                     // Out-of-range count completes with error
                     ok_next = 1'b0;
                  end else begin
                     cucfg_next = par_reg;
                     if (bc != `OWN_CFG_BYTES) begin
                        is_sa_next = 1'b0;
                        idx_next = `OWN_CFG_BYTES;
                        end_next = bc;
                        st_next = ST_XRD;
                     end
                  end
               end
               default: ok_next = 1'b0; // Opcodes not handled here
            endcase
            if (st_next == ST_WRST) begin
               mwr_next = 1'b1;
               maddr_next = blk_reg;
               mwd_next = {cmdw_reg, 1'b1, 1'b0, ok_next, 13'h0000};
            end else begin
               mrd_next = 1'b1;
               maddr_next = blk_reg + `BLK_PARAM_OFF +
                            {27'h0, idx_next[4:2], 2'h0};
            end
         end
         ST_XRD: begin
            // Take one packed word, offer its first byte
            if (mrd_reg && i_mem_ack) begin
               mrd_next = 1'b0;
               dbuf_next = i_mem_rdata;
               txv_next = 1'b1;
               txd_next = byte_sel(i_mem_rdata, idx_reg[1:0]);
               txl_next = last_byte;
               st_next = ST_XTX;
            end
         end
         ST_XTX: begin
            if (txv_reg && i_tx_ready) begin
               if (is_sa_reg) begin
                  // Byte n lands in lane n, first byte lowest
                  shad_next[{idx_reg[2:0], 3'h0} +: 8] = txd_reg;
               end else begin
                  // Snoop bits the command unit acts on
                  if (idx_reg == `CFG_PHY_BYTE) begin
                     phyw_next = 1'b1;
                     phy_next = txd_reg[`CFG_PHY_BIT];
                  end
                  if (idx_reg == `CFG_NSAI_BYTE) begin
                     // Kept inverted so the output needs no gate
                     ins_next = ~txd_reg[`CFG_NSAI_BIT];
                  end
               end
               idx_next = idx_reg + 5'h01;
               if (last_byte) begin
                  txv_next = 1'b0;
                  txl_next = 1'b0;
                  if (is_sa_reg) begin
                     // Commit only once all six bytes landed
                     sa_next = shad_next;
                  end
                  mwr_next = 1'b1;
                  maddr_next = blk_reg;
                  mwd_next = sa_word;
                  st_next = ST_WRST;
               end else if (idx_reg[1:0] == 2'h3) begin
                  // Word used up, fetch the next one
                  txv_next = 1'b0;
                  mrd_next = 1'b1;
                  maddr_next = blk_reg + `BLK_PARAM_OFF +
                               {27'h0, idx_next[4:2], 2'h0};
                  st_next = ST_XRD;
               end else begin
                  txd_next = byte_sel(dbuf_reg, idx_next[1:0]);
                  txl_next = (idx_next + 5'h01) == end_reg;
               end
            end
         end
         ST_WRST: begin
            // Status written, then follow the list flags
            if (mwr_reg && i_mem_ack) begin
               mwr_next = 1'b0;
               dn_next = cmdw_reg[`CMDW_NOTIFY_BIT];
               if (cmdw_reg[`CMDW_LAST_BIT]) begin
                  run_next = RUN_IDLE;
                  na_next = 1'b1;
                  wi_next = 1'b1;
                  st_next = ST_IDLE;
               end else if (cmdw_reg[`CMDW_SUSP_BIT]) begin
                  run_next = RUN_SUSPENDED;
                  na_next = cucfg_reg[`CFG_NA_IRQ_BIT];
                  st_next = ST_SUSP;
               end else begin
                  blk_next = base_reg + link_reg;
                  maddr_next = base_reg + link_reg;
                  mrd_next = 1'b1;
                  wcnt_next = 2'h0;
                  st_next = ST_FETCH;
               end
            end
         end
         default: st_next = ST_IDLE;
      endcase
   end

   // Engine registers
   always_ff @(posedge i_core_clk) begin
      if (i_srst) begin
         st_reg <= ST_IDLE;
         run_reg <= RUN_IDLE;
         blk_reg <= 32'h0000_0000;
         wcnt_reg <= 2'h0;
         cmdw_reg <= 16'h0000;
         link_reg <= 32'h0000_0000;
         par_reg <= 64'h0000_0000_0000_0000;
         cucfg_reg <= `OWN_CFG_RST;
         idx_reg <= 5'h00;
         end_reg <= 5'h00;
         dbuf_reg <= 32'h0000_0000;
         is_sa_reg <= 1'b0;
         ok_reg <= 1'b0;
         sa_reg <= `SA_RST;
         shad_reg <= `SA_RST;
         ins_reg <= ~`CFG_NSAI_RST;
         phyw_reg <= 1'b0;
         phy_reg <= 1'b0;
         mrd_reg <= 1'b0;
         mwr_reg <= 1'b0;
         maddr_reg <= 32'h0000_0000;
         mwd_reg <= 32'h0000_0000;
         txv_reg <= 1'b0;
         txd_reg <= 8'h00;
         txl_reg <= 1'b0;
         dn_reg <= 1'b0;
         na_reg <= 1'b0;
         wi_reg <= 1'b0;
      end else begin
         st_reg <= st_next;
         run_reg <= run_next;
         blk_reg <= blk_next;
         wcnt_reg <= wcnt_next;
         cmdw_reg <= cmdw_next;
         link_reg <= link_next;
         par_reg <= par_next;
         cucfg_reg <= cucfg_next;
         idx_reg <= idx_next;
         end_reg <= end_next;
         dbuf_reg <= dbuf_next;
         is_sa_reg <= is_sa_next;
         ok_reg <= ok_next;
         sa_reg <= sa_next;
         shad_reg <= shad_next;
         ins_reg <= ins_next;
         phyw_reg <= phyw_next;
         phy_reg <= phy_next;
         mrd_reg <= mrd_next;
         mwr_reg <= mwr_next;
         maddr_reg <= maddr_next;
         mwd_reg <= mwd_next;
         txv_reg <= txv_next;
         txd_reg <= txd_next;
         txl_reg <= txl_next;
         dn_reg <= dn_next;
         na_reg <= na_next;
         wi_reg <= wi_next;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Outputs, all from flip-flops
   ////////////////////////////////////////////////////////////////////

   assign o_avs_readdata = rdata_reg;
   assign o_avs_waitrequest = wait_reg;
   assign o_mem_rd = mrd_reg;
   assign o_mem_wr = mwr_reg;
   assign o_mem_addr = maddr_reg;
   assign o_mem_wdata = mwd_reg;
   assign o_tx_valid = txv_reg;
   assign o_tx_data = txd_reg;
   assign o_tx_is_addr = is_sa_reg;
   assign o_tx_last = txl_reg;
   assign o_station_addr = sa_reg;
   assign o_src_insert_en = ins_reg;
   // Value bit only rises together with its written flag
   assign o_link_enable = phy_reg;
   assign o_run_state = run_reg;
   assign o_cmd_done_irq = dn_reg;
   assign o_not_active_irq = na_reg;
   assign o_went_idle_irq = wi_reg;
endmodule // action_cmd_unit
`default_nettype wire

// ===== hdl/action_cmd_params.svh
// Behaviour
// - Device sets completion flag when block finishes
// - No-error flag set on success; clear means error
// - No-operation completes with both flags set
// - Opcode 001b decodes as station address setup
// - Before setup, station address reads all ones
// - Insert station address unless insertion disabled
// - Station address is receive match reference
// - Six address bytes, first byte lowest at 08h
// - 48-bit station address register resets to ones
// - Address setup streams six bytes through DMA
// - Complete setup only after register update finishes
// - Opcode 010b decodes as configure
// - Configure carries eight to twenty-two bytes
// - First eight bytes kept, rest forwarded
// - Unsupplied parameters keep their previous values
// - No traffic until interface bit written one
// - End-of-list: go idle, always raise not-active
// - Pause flag: suspend, not-active only if enabled
// - Notify flag requests command-done interrupt
// - Next block address is base plus link
// - Fetch four doublewords before decoding command
`ifndef ACTION_CMD_PARAMS_SVH
`define ACTION_CMD_PARAMS_SVH
// Command word fields (upper half of first word)
`define CMDW_LAST_BIT 15
`define CMDW_SUSP_BIT 14
`define CMDW_NOTIFY_BIT 13
`define CMDW_OP_LSB 0
`define CMD_OP_NOP 3'h0
`define CMD_OP_SA 3'h1
`define CMD_OP_CFG 3'h2
// Status word fields
`define STAT_DONE_BIT 15
`define STAT_OK_BIT 13
// Block layout and transfer sizes
`define BLK_PARAM_OFF 32'h0000_0008
`define FETCH_WORDS 2'h3
`define SA_BYTES 5'h06
`define CFG_MIN_BYTES 5'h08
`define CFG_MAX_BYTES 5'h16
`define OWN_CFG_BYTES 5'h08
// Snooped configuration bits
`define CFG_PHY_BYTE 5'h08
`define CFG_PHY_BIT 0
`define CFG_NSAI_BYTE 5'h0a
`define CFG_NSAI_BIT 3
`define CFG_NA_IRQ_BIT 51
`define CFG_NSAI_RST 1'b0
// Reset values
`define SA_RST 48'hffff_ffff_ffff
`define OWN_CFG_RST 64'h0000_0000_0000_0000
// Register word indices (Avalon address bits 5:2)
`define REG_CTRL 4'h0
`define REG_BASE 4'h1
`define REG_LIST_OFF 4'h2
`define REG_STATUS 4'h3
`define REG_SA_LO 4'h4
`define REG_SA_HI 4'h5
`define CTRL_START_BIT 0
`define CTRL_RESUME_BIT 1
`endif

// ===== hdl/action_cmd_pkg.sv
package action_cmd_pkg;
   // Command unit run states
   typedef enum logic [1:0] {
      RUN_IDLE,
      RUN_SUSPENDED,
      RUN_ACTIVE
   } run_state_t;
   // Engine sequencer states
   typedef enum logic [2:0] {
      ST_IDLE,
      ST_FETCH,
      ST_DECODE,
      ST_XRD,
      ST_XTX,
      ST_WRST,
      ST_SUSP
   } eng_state_t;
endpackage

// ===== tb/action_cmd_mem_model.sv
`timescale 1ns/1ps
`default_nettype none
module action_cmd_mem_model (
   input wire logic i_clk,
   input wire logic i_rd,
   input wire logic i_wr,
   input wire logic [31:0] i_addr,
   input wire logic [31:0] i_wdata,
   output logic o_ack,
   output logic [31:0] o_rdata
);
   logic [31:0] mem [0:511]; // Blocks, word index from byte address
   ////////////////////////////////////////////////////////////
   // Start empty so stray fetches read zero
   initial begin
      o_ack = 1'b0;
      o_rdata = 32'h0;
      for (int k = 0; k < 512; k++) begin
         mem[k] = 32'h0;
      end
   end
   ////////////////////////////////////////////////////////////
   // Random wait per request; idle data toggles every cycle
   always @(posedge i_clk) begin
      o_ack <= 1'b0;
      o_rdata <= ~o_rdata;
      if ((i_rd || i_wr) && !o_ack && ($urandom % 2 == 0)) begin
         o_ack <= 1'b1;
         if (i_rd) begin
            o_rdata <= mem[i_addr[10:2]];
         end else begin
            mem[i_addr[10:2]] <= i_wdata;
         end
      end
   end
endmodule // action_cmd_mem_model
`default_nettype wire

// ===== tb/action_cmd_props.sv
`timescale 1ns/1ps
`default_nettype none
`include "action_cmd_params.svh"
module action_cmd_props import action_cmd_pkg::*; (
   input wire logic i_core_clk,
   input wire logic i_srst,
   input wire logic o_mem_rd,
   input wire logic o_mem_wr,
   input wire logic [31:0] o_mem_addr,
   input wire logic [31:0] o_mem_wdata,
   input wire logic i_mem_ack,
   input wire logic o_tx_valid,
   input wire logic [7:0] o_tx_data,
   input wire logic o_tx_is_addr,
   input wire logic o_tx_last,
   input wire logic i_tx_ready,
   input wire logic [47:0] o_station_addr,
   input wire logic o_link_enable,
   input wire action_cmd_pkg::run_state_t o_run_state,
   input wire logic o_cmd_done_irq,
   input wire logic o_not_active_irq,
   input wire logic o_went_idle_irq
);
   wire wr_done = o_mem_wr && i_mem_ack; // Status write accepted
   wire tx_take = o_tx_valid && i_tx_ready; // Byte handed over
   default clocking tick @(posedge i_core_clk);
   endclocking
   default disable iff (i_srst);
   a_reset_addr_ones: assert property ($fell(i_srst) |-> o_station_addr == `SA_RST)
      else $error("address not ones after reset");
   a_addr_on_last: assert property ($changed(o_station_addr) |-> $past(tx_take && o_tx_last))
      else $error("address moved without last byte");
   a_link_sticks: assert property (o_link_enable |=> o_link_enable)
      else $error("link enable dropped");
   a_tx_holds: assert property (o_tx_valid && !i_tx_ready |=> o_tx_valid && $stable(o_tx_data))
      else $error("byte not held");
   a_mem_holds: assert property (o_mem_rd && !i_mem_ack |=> o_mem_rd && $stable(o_mem_addr))
      else $error("read not held");
   a_status_word: assert property (o_mem_wr |-> o_mem_wdata[15:0] inside {16'ha000, 16'h8000})
      else $error("bad status word");
   a_nop_is_ok: assert property (o_mem_wr && o_mem_wdata[18:16] == 3'h0 |-> o_mem_wdata[13])
      else $error("no-op not ok");
   a_notify_set: assert property (wr_done && o_mem_wdata[29] |=> o_cmd_done_irq)
      else $error("done pulse missing");
   a_notify_clear: assert property (wr_done && !o_mem_wdata[29] |=> !o_cmd_done_irq)
      else $error("done pulse unasked");
   a_list_end: assert property (wr_done && o_mem_wdata[31] |=> o_run_state == RUN_IDLE && o_not_active_irq)
      else $error("end of list not idle");
   a_pause_ends: assert property (wr_done && o_mem_wdata[31:30] == 2'b01 |=> o_run_state == RUN_SUSPENDED)
      else $error("pause not suspended");
endmodule // action_cmd_props
`default_nettype wire

// ===== tb/action_cmd_nop_ia_config_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module action_cmd_nop_ia_config_tb_top;
   import action_cmd_pkg::*;
   logic clk = 1'b0, srst = 1'b1, av_rd = 1'b0, av_wr = 1'b0, m_ack, tx_rdy = 1'b0;
   logic [5:0] av_a = 6'h0;
   logic [31:0] av_wd = 32'h0, av_q, m_a, m_wd, m_q, q, base;
   logic av_wait, m_rd, m_wr, tx_v, tx_a, tx_l, ins, lnk, irq_d, irq_n, irq_i, nsai;
   logic [7:0] tx_d, cfg_b [0:23], nd = 8'h0, nn = 8'h0, ni = 8'h0;
   logic [47:0] sa, sa_v;
   run_state_t st;
   logic [9:0] txq [$], expq [$]; // Bytes seen and expected on the stream
   int bad_count = 0, samples_checked = 0, cyc = 0, i;
   always #10 clk = ~clk;
   action_cmd_unit dut (.i_core_clk(clk), .i_srst(srst), .i_avs_address(av_a),
      .i_avs_read(av_rd), .i_avs_write(av_wr), .i_avs_writedata(av_wd),
      .o_avs_readdata(av_q), .o_avs_waitrequest(av_wait), .o_mem_rd(m_rd), .o_mem_wr(m_wr),
      .o_mem_addr(m_a), .o_mem_wdata(m_wd), .i_mem_ack(m_ack), .i_mem_rdata(m_q),
      .o_tx_valid(tx_v), .o_tx_data(tx_d), .o_tx_is_addr(tx_a), .o_tx_last(tx_l),
      .i_tx_ready(tx_rdy), .o_station_addr(sa), .o_src_insert_en(ins), .o_link_enable(lnk),
      .o_run_state(st), .o_cmd_done_irq(irq_d), .o_not_active_irq(irq_n),
      .o_went_idle_irq(irq_i));
   action_cmd_mem_model mem_i (.i_clk(clk), .i_rd(m_rd), .i_wr(m_wr), .i_addr(m_a),
      .i_wdata(m_wd), .o_ack(m_ack), .o_rdata(m_q));
   ////////////////////////////////////////////////////////////
   // Stalling sink, stream capture, pulse counts, watchdog
   always @(posedge clk) begin
      tx_rdy <= ($urandom % 3) != 0;
      if (!srst && tx_v && tx_rdy) txq.push_back({tx_a, tx_l, tx_d});
      if (irq_d === 1'b1) nd++;
      if (irq_n === 1'b1) nn++;
      if (irq_i === 1'b1) ni++;
      cyc++;
      if (cyc == 20000) begin
         bad_count++;
         give_verdict();
      end
   end
   task automatic give_verdict();
      $display("checked %0d bad %0d", samples_checked, bad_count);
      if (bad_count == 0 && samples_checked > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   task automatic check(input string name, input logic [47:0] seen, input logic [47:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         bad_count++;
         $display("wrong value %s expected %h seen %h", name, exp, seen);
      end
   endtask
   // One Avalon transfer, held until waitrequest is seen low
   task automatic av(input logic wr, input logic [5:0] a, input logic [31:0] d);
      @(posedge clk);
      av_a <= a;
      av_wr <= wr;
      av_rd <= !wr;
      av_wd <= d;
      do @(posedge clk); while (av_wait !== 1'b0);
      q = av_q;
      av_rd <= 1'b0;
      av_wr <= 1'b0;
   endtask
   task automatic put(input logic [7:0] off, input logic [31:0] v);
      mem_i.mem[(base + off) >> 2] = v;
   endtask
   function automatic logic [31:0] get(input logic [7:0] off);
      return mem_i.mem[(base + off) >> 2];
   endfunction
   // Start or resume, then wait for the unit to leave active
   task automatic run(input logic [31:0] ctl, input run_state_t s);
      av(1'b1, 6'h00, ctl);
      wait (st === RUN_ACTIVE);
      wait (st === s);
      repeat (2) @(posedge clk);
   endtask
   ////////////////////////////////////////////////////////////
   // Main sequence
   initial begin
      void'($urandom(32'h6dc7));
      repeat (2) @(posedge clk);
      srst <= 1'b0;
      check("addr_rst", sa, 48'hffff_ffff_ffff);
      av(1'b1, 6'h10, 32'h0);
      av(1'b0, 6'h10, 32'h0);
      check("sa_lo_rst", q, 32'hffff_ffff);
      av(1'b0, 6'h3c, 32'h0);
      check("unmapped", q, 32'h0);
      av(1'b0, 6'h0c, 32'h0);
      check("status_rst", q, 32'h4);
      base = ($urandom % 4) << 8;
      sa_v[31:0] = $urandom;
      sa_v[47:32] = $urandom;
      nsai = $urandom;
      for (i = 0; i < 24; i++) cfg_b[i] = (i < 22) ? $urandom : 8'h0;
      cfg_b[0] = 8'h16;
      cfg_b[6][3] = 1'b0;
      cfg_b[8][0] = 1'b1;
      cfg_b[10][3] = nsai;
      put(8'h40, 32'h2000_0000);
      put(8'h44, 32'h60);
      put(8'h60, 32'h0001_0000);
      put(8'h64, 32'h80);
      put(8'h68, sa_v[31:0]);
      put(8'h6c, {~sa_v[15:0], sa_v[47:32]});
      put(8'h80, 32'h8002_0000);
      for (i = 0; i < 24; i += 4)
         put(8'h88 + i, {cfg_b[i+3], cfg_b[i+2], cfg_b[i+1], cfg_b[i]});
      for (i = 0; i < 6; i++) expq.push_back({1'b1, i == 5, sa_v[8*i +: 8]});
      for (i = 8; i < 22; i++) expq.push_back({1'b0, i == 21, cfg_b[i]});
      av(1'b1, 6'h04, base);
      av(1'b1, 6'h08, 32'h40);
      run(32'h1, RUN_IDLE);
      check("nop_stat", get(8'h40), 32'h2000_a000);
      check("sa_stat", get(8'h60), 32'h0001_a000);
      check("cfg_stat", get(8'h80), 32'h8002_a000);
      check("tx_count", txq.size(), expq.size());
      for (i = 0; i < expq.size() && i < txq.size(); i++) check("tx_byte", txq[i], expq[i]);
      check("station", sa, sa_v);
      av(1'b0, 6'h14, 32'h0);
      check("sa_hi", q, sa_v[47:32]);
      check("insert", ins, !nsai);
      check("link", lnk, 1'b1);
      check("irqs", {nd, nn, ni}, 24'h010101);
      put(8'hc0, 32'h4002_0000);
      put(8'hc4, 32'he0);
      put(8'hc8, 32'h7);
      put(8'he0, 32'ha000_0000);
      av(1'b1, 6'h08, 32'hc0);
      run(32'h1, RUN_SUSPENDED);
      check("bad_cfg", get(8'hc0), 32'h4002_8000);
      check("no_fwd", txq.size(), expq.size());
      check("kept", ins, !nsai);
      check("na_pause", nn, 8'h1);
      run(32'h2, RUN_IDLE);
      check("nop_end", get(8'he0), 32'ha000_a000);
      check("irqs_end", {nd, nn, ni}, 24'h020202);
      give_verdict();
   end
endmodule // action_cmd_nop_ia_config_tb_top
bind action_cmd_unit action_cmd_props props_i (.i_core_clk, .i_srst, .o_mem_rd, .o_mem_wr,
   .o_mem_addr, .o_mem_wdata, .i_mem_ack, .o_tx_valid, .o_tx_data, .o_tx_is_addr, .o_tx_last,
   .i_tx_ready, .o_station_addr, .o_link_enable, .o_run_state, .o_cmd_done_irq,
   .o_not_active_irq, .o_went_idle_irq);
`default_nettype wire
